// ===== tsf_pkg.sv
// shared constants of the sensor serial target front end and its bus controller
package tsf_pkg;
   // core clock and bus timing
   localparam int CLK_HZ      = 25_000_000;
   localparam int TO_MIN_MS   = 15;                            // stuck-bus limit, least
   localparam int TO_MAX_MS   = 45;                            // stuck-bus limit, most
   localparam int TO_CYC      = (CLK_HZ / 1000) * TO_MIN_MS;   // least time, exact cycles
   localparam int POR_MS      = 20;                            // power-on to first command
   localparam int POR_CYC     = (CLK_HZ / 1000) * POR_MS;
   localparam int QTR_CYC     = 8;                             // controller quarter bit period

   // legacy bus codes
   localparam logic [7:0] ARA_CMD     = 8'h19;   // alert response, read
   localparam logic [6:0] GC_ADDR     = 7'h00;
   localparam logic [7:0] GC_LATCH    = 8'h04;
   localparam logic [7:0] GC_RESET    = 8'h06;
   localparam logic [4:0] HS_CODE     = 5'h01;   // 00001xxx
   localparam logic [3:0] ADDR_HI     = 4'h9;    // strapped address upper bits

   // i3c codes
   localparam logic [6:0] BCAST_ADDR  = 7'h7E;
   localparam logic [6:0] RESTR_ADDR  = 7'h5E;
   localparam logic [7:0] CCC_RSTDAA  = 8'h06;
   localparam logic [7:0] CCC_SETDASA = 8'h87;
   localparam logic [7:0] CCC_GETPID  = 8'h8D;
   localparam logic [7:0] CCC_GETBCR  = 8'h8E;
   localparam logic [7:0] CCC_GETDCR  = 8'h8F;
   localparam logic [7:0] BCR_VAL     = 8'h03;   // target, ibi capable, speed limited
   localparam logic [3:0] PID_INST    = 4'h0;
   localparam int         PID_BYTES   = 6;

   // controller register map
   localparam logic [2:0] CR_CTRL     = 3'h0;
   localparam logic [2:0] CR_TX       = 3'h1;
   localparam logic [2:0] CR_RX       = 3'h2;
   localparam logic [2:0] CR_STAT     = 3'h3;
   localparam int         CTRL_ACK    = 3;       // ack value sent after a read byte
   localparam int         ST_BUSY     = 0;
   localparam int         ST_NACK     = 1;
   localparam int         ST_ALERT    = 2;

   typedef enum logic [2:0] {OP_NONE, OP_START, OP_STOP, OP_WRITE, OP_READ} tsf_op_t;
endpackage : tsf_pkg

// ===== tsf_bus_if.sv
// two-wire bus carrier joining the bus controller and the sensor target
interface tsf_bus_if;
   logic scl_h_o;
   logic scl_h_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_t_o;
   logic sda_t_oe;
   logic alert_o;
   logic alert_oe;
   logic scl;
   logic sda;
   logic alert_n;

   // open-drain wired-and with pull-ups
   assign scl     = !(scl_h_oe && !scl_h_o);
   assign sda     = !((sda_h_oe && !sda_h_o) || (sda_t_oe && !sda_t_o));
   assign alert_n = !(alert_oe && !alert_o);

   modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, input scl, sda, alert_n);
   modport target (output sda_t_o, sda_t_oe, alert_o, alert_oe, input scl, sda);
endinterface : tsf_bus_if

// ===== tsf_target.sv
// sensor serial target: legacy bus alert, general call, hs entry, timeout, i3c sdr identity
// What this block does
// - ack alert response, return own address
// - address byte lsb flags above-high alert
// - arbitrate; clear alert on win or on general call reset
// - alert response on legacy bus only
// - alert line shared in interrupt mode
// - ack general call write, act on byte
// - general call 04 relatches address pins
// - general call 06 resets registers
// - hs master code enables fast clocks
// - stuck line timeout returns to idle
// - i3c target, single data rate only
// - setdasa assigns the dynamic address
// - fixed 48-bit provisional_identity layout
// - id low bits carry strapped address
// - restricted static address refuses setdasa
// - bus characteristics fixed value
// - characteristics read-only via get commands
// - device characteristics fixed sensor code
// - commands after power-on delay; latch pins
// - id sent six bytes, msb first
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
module tsf_target
   import tsf_pkg::*;
#(
   parameter int          TO_CYCLES  = TO_CYC,
   parameter int          POR_CYCLES = POR_CYC,
   parameter logic [14:0] MFR_ID     = 15'h2AAA,   // arbitrary value
   parameter logic [15:0] DEV_ID     = 16'h1234,   // arbitrary value
   parameter logic [7:0]  DCR_CODE   = 8'h5A       // arbitrary value
)(
   // clock and reset
   input  wire logic  CORE_CLK,
   input  wire logic  ARST_N,
   // serial bus
   tsf_bus_if.target  BUS,
   // sensor side
   input  wire logic  ALERT_EVENT,
   input  wire logic  ALERT_ABOVE,
   input  wire logic  THERMOSTAT_MODE_SELECT,
   input  wire logic  ADDR_SELECT_PIN_0,
   input  wire logic  ADDR_SELECT_PIN_1,
   input  wire logic  ADDR_SELECT_PIN_2,
   // status
   output logic       REG_RESET,
   output logic       HS_ACTIVE,
   output logic [6:0] STATIC_ADDR,
   output logic [6:0] DYN_ADDR,
   output logic       DYN_VALID
);
   typedef enum {S_IDLE, S_ADDR, S_ACK, S_WR, S_RD, S_RACK} tsf_state_t;
   typedef enum {R_NONE, R_OWN, R_DYN, R_GC, R_BC, R_ARA, R_ACK} tsf_role_t;
   localparam int PW = $clog2(POR_CYCLES + 1);
   localparam int TW = $clog2(TO_CYCLES + 1);

   logic [4:0]  s1_r, s2_r, s3_r, f_r, fp_r;
   logic [PW-1:0] por_r;
   logic [TW-1:0] to_r;
   logic        ready_r, latched_r, sda_oe_r, rd_r, mack_r, alert_r, side_r, alert_oe_r;
   logic        hs_r, rst_r, dynv_r;
   logic [7:0]  sh_r, tx_r, ccc_r;
   logic [3:0]  bit_r;
   logic [2:0]  idx_r;
   logic [6:0]  addr_r, dyn_r;
   tsf_state_t  st_r;
   tsf_role_t   role_r;

   // filtered line and pin levels, edges and bus conditions
   wire [4:0] raw   = {ADDR_SELECT_PIN_2, ADDR_SELECT_PIN_1, ADDR_SELECT_PIN_0, BUS.sda, BUS.scl};
   wire [4:0] f_nxt = (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
   wire scl   = f_r[0];
   wire sda   = f_r[1];
   wire [6:0] pin_addr = {ADDR_HI, f_r[4:2]};
   wire rise  = scl && !fp_r[0];
   wire fall  = !scl && fp_r[0];
   wire start = scl && fp_r[0] && !sda && fp_r[1];
   wire stop  = scl && fp_r[0] && sda && !fp_r[1];
   wire low   = !scl || !sda;
   wire to_hit = low && (to_r == TW'(TO_CYCLES - 1));
   wire go    = start && ready_r;
   wire quiet = !to_hit && !go && !stop;

   // address byte decode
   wire is_hs  = sh_r[7:3] == HS_CODE;
   wire ara_ok = (sh_r == ARA_CMD) && alert_r && THERMOSTAT_MODE_SELECT && !dynv_r;
   tsf_role_t addr_role;
   assign addr_role = ara_ok                                     ? R_ARA :
                      (sh_r[7:1] == GC_ADDR && !sh_r[0])          ? R_GC  :
                      (sh_r[7:1] == BCAST_ADDR && !sh_r[0])       ? R_BC  :
                      (sh_r[7:1] == addr_r)                       ? R_OWN :
                      (dynv_r && sh_r[7:1] == dyn_r)              ? R_DYN : R_NONE;
   wire setdasa_ok = role_r == R_OWN && ccc_r == CCC_SETDASA && addr_r != RESTR_ADDR;
   wire wr_byte = st_r == S_WR && fall && bit_r == 4'h8 && quiet;
   wire gc_rst  = wr_byte && role_r == R_GC && sh_r == GC_RESET;
   wire ara_win = st_r == S_RD && fall && bit_r == 4'h8 && role_r == R_ARA && quiet;

   // read data selection; identity is fixed except for the strapped address
   wire [47:0] pid = {MFR_ID, 1'b0, DEV_ID, PID_INST, 4'h0, addr_r, 1'b0};
   wire [7:0]  pid_b [PID_BYTES];
   genvar g;
   generate
      for (g = 0; g < PID_BYTES; g++) begin : g_pid
         assign pid_b[g] = pid[47 - 8 * g -: 8];
      end
   endgenerate
   wire [2:0] tx_idx = (st_r == S_ACK) ? 3'h0 : 3'(idx_r + 3'h1);
   wire get_ok = role_r == R_DYN || role_r == R_OWN;
   wire [7:0] tx_byte = (role_r == R_ARA)                      ? {addr_r, side_r} :
                        (get_ok && ccc_r == CCC_GETPID)        ? ((tx_idx < 3'(PID_BYTES)) ? pid_b[tx_idx] : 8'hFF) :
                        (get_ok && ccc_r == CCC_GETBCR)        ? BCR_VAL :
                        (get_ok && ccc_r == CCC_GETDCR)        ? DCR_CODE : 8'hFF;

   // input synchronisers, three stages with agreement
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s1_r <= 5'h1F; s2_r <= 5'h1F; s3_r <= 5'h1F; f_r <= 5'h1F; fp_r <= 5'h1F;
      end else begin
         s1_r <= raw; s2_r <= s1_r; s3_r <= s2_r; f_r <= f_nxt; fp_r <= f_r;
      end
   end

   // power-on hold-off and stuck-line timer, restarted whenever both lines are high
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         por_r <= '0; ready_r <= 1'b0; to_r <= '0;
      end else begin
         if (!ready_r) por_r <= PW'(por_r + 1'b1);
         ready_r <= ready_r || (por_r == PW'(POR_CYCLES - 1));
         to_r <= !low ? '0 : (to_r == TW'(TO_CYCLES)) ? to_r : TW'(to_r + 1'b1);
      end
   end

   // alert status: a new event wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         alert_r <= 1'b0; side_r <= 1'b0; alert_oe_r <= 1'b0; rst_r <= 1'b0;
      end else begin
         if (ALERT_EVENT) begin
            alert_r <= 1'b1;
            side_r  <= ALERT_ABOVE;
         end else if (ara_win || gc_rst) begin
            alert_r <= 1'b0;
         end
         alert_oe_r <= alert_r;
         rst_r      <= gc_rst;
      end
   end

   // bit-level target engine
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_r <= S_IDLE; role_r <= R_NONE; sh_r <= 8'h00; tx_r <= 8'hFF; bit_r <= 4'h0;
         idx_r <= 3'h0; rd_r <= 1'b0; mack_r <= 1'b1; sda_oe_r <= 1'b0; ccc_r <= 8'h00;
         hs_r <= 1'b0; dynv_r <= 1'b0; dyn_r <= 7'h00; addr_r <= 7'h00; latched_r <= 1'b0;
      end else if (to_hit) begin
         st_r <= S_IDLE; sda_oe_r <= 1'b0; role_r <= R_NONE;
      end else if (go) begin
         st_r <= S_ADDR; bit_r <= 4'h0; sda_oe_r <= 1'b0; role_r <= R_NONE;
         if (!latched_r) addr_r <= pin_addr;
         latched_r <= 1'b1;
      end else if (stop) begin
         st_r <= S_IDLE; sda_oe_r <= 1'b0; ccc_r <= 8'h00; hs_r <= 1'b0;
      end else begin
         case (st_r)
            S_ADDR, S_WR: begin
               if (rise && bit_r < 4'h8) begin
                  sh_r  <= {sh_r[6:0], sda};
                  bit_r <= bit_r + 4'h1;
               end else if (fall && bit_r == 4'h8) begin
                  st_r <= S_IDLE;
                  if (st_r == S_ADDR) begin
                     if (is_hs) hs_r <= 1'b1;
                     else if (addr_role != R_NONE) begin
                        role_r <= addr_role; rd_r <= sh_r[0]; sda_oe_r <= 1'b1; st_r <= S_ACK;
                     end
                  end else if (role_r != R_NONE) begin
                     sda_oe_r <= 1'b1;
                     st_r     <= S_ACK;
                     case (role_r)
                        R_GC: begin
                           if (sh_r == GC_LATCH) addr_r <= pin_addr;
                           role_r <= R_NONE;
                        end
                        R_BC: begin
                           ccc_r <= sh_r;
                           if (sh_r == CCC_RSTDAA) dynv_r <= 1'b0;
                           role_r <= R_ACK;
                        end
                        R_OWN: if (setdasa_ok) begin
                           dyn_r <= sh_r[7:1]; dynv_r <= 1'b1;
                        end
                        default: ;
                     endcase
                  end
               end
            end
            S_ACK: if (fall) begin
               bit_r <= rd_r ? 4'h1 : 4'h0;
               idx_r <= 3'h0;
               tx_r  <= tx_byte;
               sda_oe_r <= rd_r && !tx_byte[7];
               st_r  <= rd_r ? S_RD : S_WR;
            end
            S_RD: begin
               if (rise && !sda_oe_r && !sda) begin
                  st_r <= S_IDLE;
               end else if (fall && bit_r < 4'h8) begin
                  sda_oe_r <= !tx_r[6];
                  tx_r  <= {tx_r[6:0], 1'b1};
                  bit_r <= bit_r + 4'h1;
               end else if (fall) begin
                  sda_oe_r <= 1'b0;
                  st_r     <= S_RACK;
               end
            end
            S_RACK: begin
               if (rise) mack_r <= sda;
               else if (fall && !mack_r) begin
                  tx_r <= tx_byte; idx_r <= tx_idx; bit_r <= 4'h1;
                  sda_oe_r <= !tx_byte[7]; st_r <= S_RD;
               end else if (fall) st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // open-drain outputs and status
   assign BUS.sda_t_o  = 1'b0;
   assign BUS.sda_t_oe = sda_oe_r;
   assign BUS.alert_o  = 1'b0;
   assign BUS.alert_oe = alert_oe_r;
   assign REG_RESET    = rst_r;
   assign HS_ACTIVE    = hs_r;
   assign STATIC_ADDR  = addr_r;
   assign DYN_ADDR     = dyn_r;
   assign DYN_VALID    = dynv_r;
endmodule : tsf_target

// ===== tsf_host.sv
// bus controller end: byte-level start, stop, write and read driven from a small register port
module tsf_host
   import tsf_pkg::*;
#(
   parameter int QTR = QTR_CYC
)(
   // clock and reset
   input  wire logic       CORE_CLK,
   input  wire logic       ARST_N,
   // serial bus
   tsf_bus_if.host         BUS,
   // register port
   input  wire logic [2:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic [7:0]      REG_RDATA
);
   localparam int QW = $clog2(QTR + 1);

   tsf_op_t     op_r;
   logic [1:0]  s1_r, s2_r, s3_r, f_r;
   logic [QW-1:0] qc_r;
   logic [1:0]  ph_r;
   logic [3:0]  bit_r;
   logic [7:0]  tx_r, rx_r, rdata_r;
   logic        ackv_r, nack_r, scl_oe_r, sda_oe_r;

   // line sampling and phase timing
   wire [1:0] f_nxt = (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
   wire sda   = f_r[0];
   wire busy  = op_r != OP_NONE;
   wire tick  = busy && qc_r == QW'(QTR - 1);
   wire last  = tick && ph_r == 2'h3;
   wire data  = op_r == OP_WRITE || op_r == OP_READ;
   wire bv    = (bit_r == 4'h8) ? (op_r == OP_WRITE || ackv_r) : (op_r == OP_READ || tx_r[~bit_r[2:0]]);  // write frees ack slot
   wire scl_low = (op_r == OP_STOP) ? ph_r == 2'h0 : ph_r == 2'h0 || ph_r == 2'h3;
   wire sda_low = (op_r == OP_START) ? ph_r[1] : (op_r == OP_STOP) ? ph_r != 2'h3 : !bv;
   wire done  = last && (!data || bit_r == 4'h8);
   wire ctrl_wr = REG_WR && REG_ADDR == CR_CTRL && !busy;

   // register read mux
   wire [7:0] rd_mux = (REG_ADDR == CR_CTRL) ? {4'h0, ackv_r, op_r} :
                       (REG_ADDR == CR_TX)   ? tx_r :
                       (REG_ADDR == CR_RX)   ? rx_r :
                       (REG_ADDR == CR_STAT) ? {5'h00, !f_r[1], nack_r, busy} : 8'h00;

   // synchronisers for data and alert lines
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s1_r <= 2'h3; s2_r <= 2'h3; s3_r <= 2'h3; f_r <= 2'h3;
      end else begin
         s1_r <= {BUS.alert_n, BUS.sda}; s2_r <= s1_r; s3_r <= s2_r; f_r <= f_nxt;
      end
   end

   // register writes and reads
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tx_r <= 8'h00; ackv_r <= 1'b0; rdata_r <= 8'h00;
      end else begin
         if (REG_WR && REG_ADDR == CR_TX) tx_r <= REG_WDATA;
         if (ctrl_wr) ackv_r <= REG_WDATA[CTRL_ACK];
         rdata_r <= REG_RD ? rd_mux : 8'h00;
      end
   end

   // sequencer: four phases per bit, start or stop
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         op_r <= OP_NONE; qc_r <= '0; ph_r <= 2'h0; bit_r <= 4'h0; rx_r <= 8'h00;
         nack_r <= 1'b0; scl_oe_r <= 1'b0; sda_oe_r <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            op_r <= tsf_op_t'(REG_WDATA[2:0]);
            qc_r <= '0; ph_r <= 2'h0; bit_r <= 4'h0;
         end else if (busy) begin
            qc_r <= tick ? '0 : QW'(qc_r + 1'b1);
            if (tick) ph_r <= ph_r + 2'h1;
            if (tick && ph_r == 2'h2 && data && bit_r == 4'h8 && op_r == OP_WRITE) nack_r <= sda;
            if (tick && ph_r == 2'h2 && op_r == OP_READ && bit_r < 4'h8) rx_r <= {rx_r[6:0], sda};
            if (last && bit_r < 4'h8) bit_r <= bit_r + 4'h1;
            if (done) op_r <= OP_NONE;
         end
         scl_oe_r <= busy ? scl_low : scl_oe_r;
         sda_oe_r <= busy ? sda_low : sda_oe_r;
      end
   end

   assign BUS.scl_h_o  = 1'b0;
   assign BUS.scl_h_oe = scl_oe_r;
   assign BUS.sda_h_o  = 1'b0;
   assign BUS.sda_h_oe = sda_oe_r;
   assign REG_RDATA    = rdata_r;
endmodule : tsf_host

// ===== tsf_checker.sv
// wire-level assertions for the bus joining the controller and the sensor target
module tsf_checker
   import tsf_pkg::*;
#(
   parameter int TO_CYCLES  = TO_CYC,
   parameter int POR_CYCLES = POR_CYC
)(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   // resolved lines and target drives
   input wire logic scl,
   input wire logic sda,
   input wire logic alert_n,
   input wire logic sda_t_o,
   input wire logic sda_t_oe,
   input wire logic alert_oe
);
   int unsigned por_r;
   int unsigned sl_r;
   int unsigned dl_r;
   wire         stuck = (sl_r > TO_CYCLES + 8) || (dl_r > TO_CYCLES + 8);

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   // cycles since reset release and run lengths of clock and data held low
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         por_r <= 0;
         sl_r  <= 0;
         dl_r  <= 0;
      end else begin
         por_r <= (por_r < POR_CYCLES) ? por_r + 1 : por_r;
         sl_r  <= scl ? 0 : sl_r + 1;
         dl_r  <= sda ? 0 : dl_r + 1;
      end
   end

   a_moves_clock_low: assert property (($changed(sda_t_oe) && dl_r < TO_CYCLES) |-> !scl)
      else $error("target data moved while clock high");
   a_drive_pulls_low: assert property (sda_t_oe |-> !sda_t_o && !sda)
      else $error("target drive does not pull data low");
   a_bit_held_long: assert property ($rose(sda_t_oe) |-> sda_t_oe [*8])
      else $error("target bit shorter than a clock phase");
   a_stuck_bus_free: assert property (stuck |-> !sda_t_oe)
      else $error("target holds data after stuck bus limit");
   a_quiet_at_start: assert property ($rose(ARST_N) |-> !sda_t_oe && !alert_oe)
      else $error("target drives a line right after reset");
   a_power_on_quiet: assert property (por_r < POR_CYCLES |-> !sda_t_oe)
      else $error("target answered before power-on delay");
   a_alert_clear_low: assert property ($fell(alert_oe) |-> !scl)
      else $error("alert released outside clock low phase");
   a_alert_held_min: assert property ($rose(alert_oe) |-> alert_oe [*8])
      else $error("alert line pulse too short");
   a_alert_on_line: assert property (alert_oe |-> !alert_n)
      else $error("alert drive not seen on line");

   // main scenarios reached
   c_target_drives: cover property ($rose(sda_t_oe));
   c_alert_raised: cover property ($rose(alert_oe));
   c_alert_served: cover property ($rose(alert_oe) ##[1:1000] $fell(alert_oe));
endmodule : tsf_checker

// ===== test_sensor_serial_target_front_end.sv
// self-checking bench: controller and sensor target joined on one bus
module test_sensor_serial_target_front_end import tsf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int          TO_T  = 2000;
   localparam int          POR_T = 50;
   localparam logic [14:0] MFR_T = 15'h1357;  // arbitrary value
   localparam logic [15:0] DEV_T = 16'h2468;  // arbitrary value
   localparam logic [7:0]  DCR_T = 8'h3C;     // arbitrary value

   logic        clk     = 1'b0;
   logic        arst_n  = 1'b0;
   logic [2:0]  r_addr  = 3'h0;
   logic [7:0]  r_wdata = 8'h00;
   logic        r_wr    = 1'b0;
   logic        r_rd    = 1'b0;
   logic [7:0]  r_rdata;
   logic        ev      = 1'b0;
   logic        above   = 1'b0;
   logic        tm      = 1'b0;
   logic [2:0]  pins    = 3'h0;
   logic        reg_rst;
   logic        hs;
   logic [6:0]  st_addr;
   logic [6:0]  dyn_addr;
   logic        dyn_v;
   logic [6:0]  sa;
   logic [31:0] seed    = 32'h1616;
   int          mismatches = 0;
   int          checked    = 0;
   int          rr_cnt     = 0;

   tsf_bus_if bus ();
   tsf_host #(.QTR(QTR_CYC)) tsf_host_i (.CORE_CLK(clk), .ARST_N(arst_n), .BUS(bus), .REG_ADDR(r_addr),
      .REG_WDATA(r_wdata), .REG_WR(r_wr), .REG_RD(r_rd), .REG_RDATA(r_rdata));
   tsf_target #(.TO_CYCLES(TO_T), .POR_CYCLES(POR_T), .MFR_ID(MFR_T), .DEV_ID(DEV_T), .DCR_CODE(DCR_T))
      tsf_target_i (.CORE_CLK(clk), .ARST_N(arst_n), .BUS(bus), .ALERT_EVENT(ev), .ALERT_ABOVE(above),
      .THERMOSTAT_MODE_SELECT(tm), .ADDR_SELECT_PIN_0(pins[0]), .ADDR_SELECT_PIN_1(pins[1]),
      .ADDR_SELECT_PIN_2(pins[2]), .REG_RESET(reg_rst), .HS_ACTIVE(hs), .STATIC_ADDR(st_addr),
      .DYN_ADDR(dyn_addr), .DYN_VALID(dyn_v));
   tsf_checker #(.TO_CYCLES(TO_T), .POR_CYCLES(POR_T)) tsf_checker_i (.CORE_CLK(clk), .ARST_N(arst_n),
      .scl(bus.scl), .sda(bus.sda), .alert_n(bus.alert_n), .sda_t_o(bus.sda_t_o), .sda_t_oe(bus.sda_t_oe),
      .alert_oe(bus.alert_oe));

   // clock and count of reset pulses from the target
   always #20 clk = ~clk;
   always @(posedge clk) if (reg_rst === 1'b1) rr_cnt++;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // register port of the controller
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      r_addr  <= a;
      r_wdata <= d;
      r_wr    <= 1'b1;
      @(posedge clk);
      r_wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      r_addr <= a;
      r_rd   <= 1'b1;
      @(posedge clk);
      r_rd <= 1'b0;
      #1 d = r_rdata;
   endtask : reg_rd

   // one bus operation, polling busy under a bound
   task automatic op(input logic ack, input tsf_op_t c);
      logic [7:0] s;
      int         i;
      reg_wr(CR_CTRL, {4'h0, ack, c});
      for (i = 0; i < 1000; i++) begin
         reg_rd(CR_STAT, s);
         if (s[ST_BUSY] === 1'b0) break;
      end
      if (i == 1000) begin
         chk("busy", 1'b1, 1'b0);
         print_verdict();
      end
   endtask : op

   task automatic wr_byte(input logic [7:0] b, output logic nack);
      logic [7:0] s;
      reg_wr(CR_TX, b);
      op(1'b0, OP_WRITE);
      reg_rd(CR_STAT, s);
      nack = s[ST_NACK];
   endtask : wr_byte

   // broadcast header and command byte after a start
   task automatic bcast(input logic [7:0] c);
      logic n;
      op(1'b0, OP_START);
      wr_byte({BCAST_ADDR, 1'b0}, n);
      wr_byte(c, n);
   endtask : bcast

   task automatic get_ccc(input logic [7:0] c, input int nb, input logic [47:0] exp);
      logic [7:0]  d;
      logic        n;
      logic [47:0] got;
      got = 48'h0;
      bcast(c);
      op(1'b0, OP_START);
      wr_byte({sa, 1'b1}, n);
      chk("direct address ack", n, 1'b0);
      for (int i = 0; i < nb; i++) begin
         op(i == nb - 1, OP_READ);
         reg_rd(CR_RX, d);
         got = {got[39:0], d};
      end
      op(1'b0, OP_STOP);
      chk("get reply", got, exp);
   endtask : get_ccc

   task automatic pulse(input logic hi);
      @(posedge clk);
      ev    <= 1'b1;
      above <= hi;
      @(posedge clk);
      ev <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : pulse

   // alert response: refused or answered with address and limit side
   task automatic ara(input logic nk, input logic hi);
      logic [7:0] d;
      logic       n;
      op(1'b0, OP_START);
      wr_byte(ARA_CMD, n);
      chk("alert command ack", n, nk);
      if (!nk) begin
         op(1'b1, OP_READ);
         reg_rd(CR_RX, d);
         chk("alert reply", d, {sa, hi});
      end
      op(1'b0, OP_STOP);
   endtask : ara

   initial begin
      logic [7:0]  d;
      logic        n;
      logic [31:0] r;
      int          k;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (POR_T + 10) @(posedge clk);
      r = rnd();
      pins <= r[2:0];
      op(1'b0, OP_START);
      op(1'b0, OP_STOP);
      sa = {4'h9, r[2:0]};
      chk("static address", st_addr, sa);
      @(posedge clk);
      pins <= ~r[2:0];
      op(1'b0, OP_START);
      wr_byte({GC_ADDR, 1'b0}, n);
      chk("general call ack", n, 1'b0);
      wr_byte(GC_LATCH, n);
      op(1'b0, OP_STOP);
      sa = {4'h9, ~r[2:0]};
      chk("relatched address", st_addr, sa);
      $display("test address select finished");
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         tm <= 1'b1;
         ara(1'b1, 1'b0);
         @(posedge clk);
         tm <= 1'b0;
         pulse(k[0]);
         reg_rd(CR_STAT, d);
         chk("alert line", d[ST_ALERT], 1'b1);
         ara(1'b1, 1'b0);
         @(posedge clk);
         tm <= 1'b1;
         ara(1'b0, k[0]);
         repeat (10) @(posedge clk);
         reg_rd(CR_STAT, d);
         chk("alert after win", d[ST_ALERT], 1'b0);
      end
      $display("test alert response finished");
      pulse(1'b1);
      k = rr_cnt;
      op(1'b0, OP_START);
      wr_byte({GC_ADDR, 1'b0}, n);
      wr_byte(GC_RESET, n);
      chk("reset command ack", n, 1'b0);
      op(1'b0, OP_STOP);
      chk("reset pulses", rr_cnt - k, 48'h1);
      reg_rd(CR_STAT, d);
      chk("alert after reset", d[ST_ALERT], 1'b0);
      $display("test general call reset finished");
      r = rnd();
      op(1'b0, OP_START);
      wr_byte({HS_CODE, r[2:0]}, n);
      chk("master code ack", n, 1'b1);
      chk("fast mode", hs, 1'b1);
      op(1'b0, OP_STOP);
      chk("fast mode after stop", hs, 1'b0);
      $display("test high speed finished");
      get_ccc(CCC_GETPID, PID_BYTES, {MFR_T, 1'b0, DEV_T, 4'h0, 4'h0, sa, 1'b0});
      get_ccc(CCC_GETBCR, 1, 48'h03);
      get_ccc(CCC_GETDCR, 1, {40'h0, DCR_T});
      $display("test identity finished");
      r = rnd();
      bcast(CCC_SETDASA);
      op(1'b0, OP_START);
      wr_byte({sa, 1'b0}, n);
      wr_byte({r[6:0], 1'b0}, n);
      op(1'b0, OP_STOP);
      chk("dynamic address", dyn_addr, r[6:0]);
      chk("dynamic valid", dyn_v, 1'b1);
      bcast(CCC_RSTDAA);
      op(1'b0, OP_STOP);
      chk("dynamic valid cleared", dyn_v, 1'b0);
      $display("test dynamic address finished");
      bcast(CCC_GETPID);
      op(1'b0, OP_START);
      wr_byte({sa, 1'b1}, n);
      chk("data held by target", bus.sda, 1'b0);
      repeat (TO_T + 20) @(posedge clk);
      chk("data released after stuck limit", bus.sda, 1'b1);
      op(1'b0, OP_STOP);
      chk("address kept after stuck limit", st_addr, sa);
      $display("test stuck bus finished");
      print_verdict();
   end
endmodule : test_sensor_serial_target_front_end
